// [design/lcr_pkg.sv]
// constants and types of the line interface control and interrupt registers
// Behaviour
// - receiver power follows its turn-on bit
// - transmitter off tri-states the line output pair
// - driver-fail enable gates driver-fail interrupt
// - signal-loss enable gates signal-loss interrupt
// - lock-loss enable gates lock-loss interrupt
// - fifo-limit enable gates near-limit interrupt
// - no fifo-limit interrupt while attenuator disabled
// - pattern-error enable lets bit errors interrupt
// - driver-fail flag latches change, clears on read
// - signal-loss flag latches change, clears on read
// - lock-loss flag latches change, clears on read
// - fifo-limit flag latches change, clears on read
// - pattern-error flag latches error, clears on read
// - counter-full flag latches saturation, clears on read
// - part identifier is read-only
// - interrupt output active low
// - alarm status read flushes attenuator fifo
package lcr_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int CNT_W = 16;
   localparam int NUM_FLAGS = 6;
   localparam int NUM_LEVELS = 4;

   typedef logic [ADDR_W-1:0] lcr_addr_t;
   typedef logic [DATA_W-1:0] lcr_byte_t;

   // register offsets
   localparam lcr_addr_t OFF_REDUNDANCY = 6'h00;
   localparam lcr_addr_t OFF_IRQ_EN = 6'h01;
   localparam lcr_addr_t OFF_IRQ_STAT = 6'h02;
   localparam lcr_addr_t OFF_ALARM = 6'h03;
   localparam lcr_addr_t OFF_GIRQ_EN = 6'h20;
   localparam lcr_addr_t OFF_GIRQ_STAT = 6'h21;
   localparam lcr_addr_t OFF_CNT_HI = 6'h30;
   localparam lcr_addr_t OFF_CNT_LO = 6'h31;
   localparam lcr_addr_t OFF_HOLD = 6'h38;
   localparam lcr_addr_t OFF_PART = 6'h3E;
   localparam lcr_addr_t OFF_REV = 6'h3F;

   // field positions
   localparam int BIT_TX_ON = 0;
   localparam int BIT_RX_ON = 4;
   localparam int BIT_GIE = 0;
   localparam int BIT_GSTAT = 0;
   localparam int IDX_DRV = 0;
   localparam int IDX_SIG = 1;
   localparam int IDX_LOCK = 2;
   localparam int IDX_FIFO = 3;
   localparam int IDX_PAT = 4;
   localparam int IDX_SAT = 5;

   // reset values
   localparam logic RST_TX_ON = 1'b0;
   localparam logic RST_RX_ON = 1'b0;
   localparam logic [NUM_FLAGS-1:0] RST_IRQ_EN = 6'h00;
   localparam logic RST_GIE = 1'b0;
   localparam logic RST_FLAG = 1'b0;
   localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;
   localparam lcr_byte_t RST_BYTE = 8'h00;

   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

   // serial frame: rw, six address bits, one spare, eight data bits
   localparam int FR_CNT_W = 5;
   localparam logic [FR_CNT_W-1:0] FR_RW = 5'h00;
   localparam logic [FR_CNT_W-1:0] FR_SPARE = 5'h07;
   localparam logic [FR_CNT_W-1:0] FR_DATA = 5'h08;
   localparam logic [FR_CNT_W-1:0] FR_LAST = 5'h0F;
   localparam logic [FR_CNT_W-1:0] FR_LEN = 5'h10;

   // identification, values arbitrary
   localparam lcr_byte_t PART_ID_DEFAULT = 8'h5A;
   localparam lcr_byte_t REV_ID_DEFAULT = 8'h01;
endpackage : lcr_pkg

// [design/lcr_flag.sv]
// one sticky interrupt flag, set wins over clear
`timescale 1ns/100ps
module lcr_flag
   import lcr_pkg::*;
#(
   parameter logic RST_VAL = RST_FLAG
) (
   input wire logic mclk,  // system clock
   input wire logic rst_b, // async reset
   input wire logic set,   // event pulse
   input wire logic clr,   // clear pulse
   output logic flag       // sticky flag
);
   typedef struct packed {
      logic flag;
   } lcr_flag_s;

   lcr_flag_s st_r;
   lcr_flag_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (clr) begin
         st_nxt.flag = 1'b0;
      end
      if (set) begin
         st_nxt.flag = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r.flag <= RST_VAL;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign flag = st_r.flag;
endmodule : lcr_flag

// [design/lcr_serial_port.sv]
// serial host port slave: frame decode, read and write strobes
`timescale 1ns/100ps
module lcr_serial_port
   import lcr_pkg::*;
(
   input wire logic mclk,        // system clock
   input wire logic rst_b,       // async reset
   input wire logic sclk,        // host serial clock
   input wire logic cs_b,        // host chip select
   input wire logic sdi,         // host serial data in
   output logic sdo,             // serial data out
   output logic sdo_oe,          // sdo driven
   output logic rd_stb,          // read pulse
   output logic wr_stb,          // write pulse
   output lcr_addr_t addr,       // register offset
   output lcr_byte_t wdata,      // write byte
   input wire lcr_byte_t rdata   // read byte
);
   typedef struct packed {
      logic [FR_CNT_W-1:0] cnt;
      logic sclk_q;
      logic rw;
      lcr_addr_t addr;
      lcr_byte_t shin;
      lcr_byte_t shout;
      logic oe;
      logic rd;
      logic wr;
   } lcr_sp_s;

   lcr_sp_s st_r;
   lcr_sp_s st_nxt;
   logic rise;
   logic fall;

   assign rise = sclk & ~st_r.sclk_q;
   assign fall = ~sclk & st_r.sclk_q;

   always_comb begin
      st_nxt = st_r;
      st_nxt.sclk_q = sclk;
      st_nxt.rd = 1'b0;
      st_nxt.wr = 1'b0;
      if (cs_b) begin
         st_nxt.cnt = FR_RW;
         st_nxt.oe = 1'b0;
      end else begin
         if (rise && (st_r.cnt < FR_LEN)) begin
            st_nxt.cnt = st_r.cnt + 5'h01;
            if (st_r.cnt == FR_RW) begin
               st_nxt.rw = sdi;
            end else if (st_r.cnt < FR_SPARE) begin
               st_nxt.addr = {st_r.addr[ADDR_W-2:0], sdi};
            end else if (st_r.cnt >= FR_DATA) begin
               st_nxt.shin = {st_r.shin[DATA_W-2:0], sdi};
            end
            if (st_r.cnt == FR_SPARE) begin
               st_nxt.rd = st_r.rw;
               st_nxt.oe = st_r.rw;
            end
            if (st_r.cnt == FR_LAST) begin
               st_nxt.wr = ~st_r.rw;
            end
         end
         // next bit out after each falling edge of the data phase
         if (fall && (st_r.cnt > FR_DATA)) begin
            st_nxt.shout = {st_r.shout[DATA_W-2:0], 1'b0};
         end
         if (st_r.rd) begin
            st_nxt.shout = rdata;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sdo = st_r.shout[DATA_W-1];
   assign sdo_oe = st_r.oe;
   assign rd_stb = st_r.rd;
   assign wr_stb = st_r.wr;
   assign addr = st_r.addr;
   assign wdata = st_r.shin;
endmodule : lcr_serial_port

// [design/lcr_regs.sv]
// control and interrupt register bank behind the serial host port
`timescale 1ns/100ps
module lcr_regs
   import lcr_pkg::*;
#(
   parameter lcr_byte_t PART_ID = PART_ID_DEFAULT, // arbitrary value
   parameter lcr_byte_t REV_ID = REV_ID_DEFAULT    // arbitrary value
) (
   input wire logic mclk,                 // 10 MHz clock
   input wire logic rst_b,                // async reset
   input wire logic sclk,                 // host serial clock
   input wire logic cs_b,                 // host chip select
   input wire logic sdi,                  // host serial data in
   output logic sdo,                      // serial data out
   output logic sdo_oe,                   // sdo driven
   output logic irq_b,                    // interrupt, active low
   input wire logic driver_monitor_alarm, // driver failure level
   input wire logic receive_signal_loss,  // loss of signal level
   input wire logic receive_lock_loss,    // loss of lock level
   input wire logic fifo_near_limit,      // fifo within two bits
   input wire logic jitter_att_enabled,   // attenuator in use
   input wire logic pattern_bit_error,    // one pulse per error
   output logic receiver_turn_on,         // receiver powered
   output logic transmitter_turn_on,      // transmitter on
   output logic line_output_pair_oe,      // line output driven
   output logic fifo_flush                // flush pulse
);
   typedef struct packed {
      logic rx_on;
      logic tx_on;
      logic [NUM_FLAGS-1:0] irq_en;
      logic gie;
      logic [CNT_W-1:0] cnt;
      lcr_byte_t hold;
      logic [NUM_LEVELS-1:0] lvl_q;
      logic irq_b;
      logic flush;
   } lcr_regs_s;

   lcr_regs_s st_r;
   lcr_regs_s st_nxt;

   logic rd_stb;
   logic wr_stb;
   lcr_addr_t addr;
   lcr_byte_t wdata;
   lcr_byte_t rdata;
   logic [NUM_FLAGS-1:0] flags;
   logic [NUM_FLAGS-1:0] flag_set;
   logic [NUM_FLAGS-1:0] flag_clr;
   logic [NUM_FLAGS-1:0] pending;
   logic [NUM_LEVELS-1:0] lvl;
   logic any_pending;
   logic rd_stat;

   lcr_serial_port u_port (
      .mclk(mclk),
      .rst_b(rst_b),
      .sclk(sclk),
      .cs_b(cs_b),
      .sdi(sdi),
      .sdo(sdo),
      .sdo_oe(sdo_oe),
      .rd_stb(rd_stb),
      .wr_stb(wr_stb),
      .addr(addr),
      .wdata(wdata),
      .rdata(rdata)
   );

   // alarm levels watched for change; fifo level ignored when off
   always_comb begin
      lvl = '0;
      lvl[IDX_DRV] = driver_monitor_alarm;
      lvl[IDX_SIG] = receive_signal_loss;
      lvl[IDX_LOCK] = receive_lock_loss;
      lvl[IDX_FIFO] = fifo_near_limit & jitter_att_enabled;
   end

   assign rd_stat = rd_stb && (addr == OFF_IRQ_STAT);

   always_comb begin
      flag_set = '0;
      flag_set[IDX_DRV] = lvl[IDX_DRV] ^ st_r.lvl_q[IDX_DRV];
      flag_set[IDX_SIG] = lvl[IDX_SIG] ^ st_r.lvl_q[IDX_SIG];
      flag_set[IDX_LOCK] = lvl[IDX_LOCK] ^ st_r.lvl_q[IDX_LOCK];
      flag_set[IDX_FIFO] = lvl[IDX_FIFO] ^ st_r.lvl_q[IDX_FIFO];
      flag_set[IDX_PAT] = pattern_bit_error;
      flag_set[IDX_SAT] = (st_nxt.cnt == CNT_MAX)
         && (st_r.cnt != CNT_MAX);
      flag_clr = {NUM_FLAGS{rd_stat}};
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
         lcr_flag #(
            .RST_VAL(RST_FLAG)
         ) u_flag (
            .mclk(mclk),
            .rst_b(rst_b),
            .set(flag_set[gi]),
            .clr(flag_clr[gi]),
            .flag(flags[gi])
         );
      end
   endgenerate

   always_comb begin
      pending = flags & st_r.irq_en;
      pending[IDX_FIFO] = flags[IDX_FIFO] & st_r.irq_en[IDX_FIFO]
         & jitter_att_enabled;
   end

   assign any_pending = |pending;

   // read data, reserved offsets and bits zero
   always_comb begin
      rdata = RST_BYTE;
      unique case (addr)
         OFF_REDUNDANCY: begin
            rdata[BIT_RX_ON] = st_r.rx_on;
            rdata[BIT_TX_ON] = st_r.tx_on;
         end
         OFF_IRQ_EN: begin
            rdata[NUM_FLAGS-1:0] = st_r.irq_en;
         end
         OFF_IRQ_STAT: begin
            rdata[NUM_FLAGS-1:0] = flags;
         end
         OFF_ALARM: begin
            rdata[NUM_LEVELS-1:0] = lvl;
         end
         OFF_GIRQ_EN: begin
            rdata[BIT_GIE] = st_r.gie;
         end
         OFF_GIRQ_STAT: begin
            rdata[BIT_GSTAT] = any_pending;
         end
         OFF_CNT_HI: begin
            rdata = st_r.cnt[CNT_W-1:DATA_W];
         end
         OFF_CNT_LO: begin
            rdata = st_r.cnt[DATA_W-1:0];
         end
         OFF_HOLD: begin
            rdata = st_r.hold;
         end
         OFF_PART: begin
            rdata = PART_ID;
         end
         OFF_REV: begin
            rdata = REV_ID;
         end
         default: begin
            rdata = RST_BYTE;
         end
      endcase
   end

   always_comb begin
      st_nxt = st_r;
      st_nxt.lvl_q = lvl;
      st_nxt.flush = rd_stb && (addr == OFF_ALARM);
      // reading the high byte snapshots the low byte and restarts
      if (rd_stb && (addr == OFF_CNT_HI)) begin
         st_nxt.hold = st_r.cnt[DATA_W-1:0];
         st_nxt.cnt = RST_CNT;
         if (pattern_bit_error) begin
            st_nxt.cnt = CNT_ONE;
         end
      end else if (pattern_bit_error && (st_r.cnt != CNT_MAX)) begin
         st_nxt.cnt = st_r.cnt + CNT_ONE;
      end
      // writes to read-only or reserved offsets are dropped
      if (wr_stb) begin
         unique case (addr)
            OFF_REDUNDANCY: begin
               st_nxt.rx_on = wdata[BIT_RX_ON];
               st_nxt.tx_on = wdata[BIT_TX_ON];
            end
            OFF_IRQ_EN: begin
               st_nxt.irq_en = wdata[NUM_FLAGS-1:0];
            end
            OFF_GIRQ_EN: begin
               st_nxt.gie = wdata[BIT_GIE];
            end
            default: begin
               st_nxt.gie = st_r.gie;
            end
         endcase
      end
      st_nxt.irq_b = ~(st_r.gie & any_pending);
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r.rx_on <= RST_RX_ON;
         st_r.tx_on <= RST_TX_ON;
         st_r.irq_en <= RST_IRQ_EN;
         st_r.gie <= RST_GIE;
         st_r.cnt <= RST_CNT;
         st_r.hold <= RST_BYTE;
         st_r.lvl_q <= '0;
         st_r.irq_b <= 1'b1;
         st_r.flush <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign irq_b = st_r.irq_b;
   assign receiver_turn_on = st_r.rx_on;
   assign transmitter_turn_on = st_r.tx_on;
   assign line_output_pair_oe = st_r.tx_on;
   assign fifo_flush = st_r.flush;
endmodule : lcr_regs

// [verif/lcr_regs_sva.sv]
// port assertions for the control and interrupt register bank
`timescale 1ns/100ps
module lcr_regs_sva (
   input wire logic mclk,                // clock
   input wire logic rst_b,               // async reset
   input wire logic cs_b,                // chip select
   input wire logic sdo_oe,              // sdo driven
   input wire logic irq_b,               // interrupt
   input wire logic receiver_turn_on,    // receiver on
   input wire logic transmitter_turn_on, // transmitter on
   input wire logic line_output_pair_oe, // line driven
   input wire logic fifo_flush,          // flush pulse
   input wire logic jitter_att_enabled   // attenuator in use
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   logic cs_seen_r;
   // global enable starts off, so only a frame can arm the output
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cs_seen_r <= 1'b0;
      end else begin
         cs_seen_r <= cs_seen_r | ~cs_b;
      end
   end
   a_line_oe_match: assert property (
      line_output_pair_oe == transmitter_turn_on)
      else $error("line output enable differs from transmitter bit");
   a_rx_by_write: assert property (
      $changed(receiver_turn_on) |-> !$past(cs_b, 2))
      else $error("receiver bit changed outside a frame");
   a_tx_by_write: assert property (
      $changed(transmitter_turn_on) |-> !$past(cs_b, 2))
      else $error("transmitter bit changed outside a frame");
   a_flush_single: assert property (
      fifo_flush |=> !fifo_flush)
      else $error("flush pulse longer than one cycle");
   a_flush_in_read: assert property (
      fifo_flush |-> sdo_oe && !cs_b)
      else $error("flush pulse outside a read frame");
   a_rise_quiet: assert property (
      $rose(rst_b) |-> irq_b && !sdo_oe && !fifo_flush)
      else $error("outputs active right after reset");
   a_irq_needs_gie: assert property (
      !irq_b |-> cs_seen_r)
      else $error("interrupt before any enable was written");
   // attenuator switched off also masks a pending fifo source
   a_irq_clear_frame: assert property (
      $rose(irq_b) && ($past(jitter_att_enabled)
      == $past(jitter_att_enabled, 2)) |-> !$past(cs_b, 2))
      else $error("interrupt released without host access");
endmodule : lcr_regs_sva

bind lcr_regs lcr_regs_sva u_sva (.mclk, .rst_b, .cs_b, .sdo_oe, .irq_b,
   .receiver_turn_on, .transmitter_turn_on, .line_output_pair_oe,
   .fifo_flush, .jitter_att_enabled);

// [verif/lcr_host_model.sv]
// host serial master model for the register bank
`timescale 1ns/100ps
module lcr_host_model
   import lcr_pkg::*;
(
   input wire logic mclk,   // clock
   output logic sclk,       // still between frames
   output logic cs_b,       // chip select
   output logic sdi,        // data to device
   input wire logic sdo,    // data from device
   input wire logic sdo_oe  // device drives sdo
);
   initial begin
      sclk = 1'b0;
      cs_b = 1'b1;
      sdi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   // one frame, each sclk level held three cycles
   task automatic xfer(input logic rd, input lcr_addr_t a,
                       input lcr_byte_t wd, output lcr_byte_t q);
      logic [15:0] fr;
      fr = {rd, a, 1'b0, wd};
      q = 8'h00;
      tick(1);
      cs_b = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdi = fr[i];
         tick(3);
         sclk = 1'b1;
         if (i < 8) q[i] = sdo_oe ? sdo : 1'bx;
         tick(3);
         sclk = 1'b0;
      end
      tick(6);
      cs_b = 1'b1;
      sdi = ~sdi;
      tick(3);
   endtask : xfer
endmodule : lcr_host_model

// [verif/tb_liu_control_interrupt_regs.sv]
// self-checking bench for the control and interrupt register bank
`timescale 1ns/100ps
module tb_liu_control_interrupt_regs;
   import lcr_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic sclk, cs_b, sdi, sdo, sdo_oe, irq_b, rx_on, tx_on, line_oe, flush;
   logic [3:0] lvl = 4'h0;
   logic ja = 1'b0;
   logic perr = 1'b0;
   int bad_count = 0;
   int tests_run = 0;
   int flush_cnt = 0;
   lcr_byte_t q;
   always #50 mclk = ~mclk;
   always @(posedge mclk) if (flush === 1'b1) flush_cnt++;
   lcr_regs DUT (.mclk, .rst_b, .sclk, .cs_b, .sdi, .sdo, .sdo_oe, .irq_b,
      .driver_monitor_alarm(lvl[0]), .receive_signal_loss(lvl[1]),
      .receive_lock_loss(lvl[2]), .fifo_near_limit(lvl[3]),
      .jitter_att_enabled(ja), .pattern_bit_error(perr),
      .receiver_turn_on(rx_on), .transmitter_turn_on(tx_on),
      .line_output_pair_oe(line_oe), .fifo_flush(flush));
   lcr_host_model host (.mclk, .sclk, .cs_b, .sdi, .sdo, .sdo_oe);
   task automatic finish_test;
      if (bad_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input string n, input lcr_byte_t e, input lcr_byte_t s);
      tests_run++;
      if (s !== e) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic rd(input lcr_addr_t a, input lcr_byte_t e, input string n);
      host.xfer(1'b1, a, 8'h00, q);
      chk(n, e, q);
   endtask : rd
   task automatic wr(input lcr_addr_t a, input lcr_byte_t d);
      host.xfer(1'b0, a, d, q);
   endtask : wr
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic irq(input string n, input logic e);
      chk(n, {7'h00, e}, {7'h00, irq_b});
   endtask : irq
   task automatic s_reset;
      lcr_addr_t offs [7] = '{OFF_REDUNDANCY, OFF_IRQ_EN, OFF_IRQ_STAT,
         OFF_GIRQ_EN, OFF_GIRQ_STAT, OFF_CNT_HI, OFF_PART};
      irq("irq after reset", 1'b1);
      for (int i = 0; i < 7; i++) begin
         rd(offs[i], (i == 6) ? PART_ID_DEFAULT : 8'h00, "reset value");
      end
   endtask : s_reset
   task automatic s_ctrl;
      wr(OFF_REDUNDANCY, 8'hFF);
      rd(OFF_REDUNDANCY, 8'h11, "ctrl readback");
      chk("both on", 8'h07, {5'h00, rx_on, tx_on, line_oe});
      wr(OFF_REDUNDANCY, 8'h10);
      chk("tx off", 8'h04, {5'h00, rx_on, tx_on, line_oe});
      wr(OFF_REDUNDANCY, 8'h00);
      chk("rx off", 8'h00, {5'h00, rx_on, tx_on, line_oe});
      wr(OFF_PART, 8'h00);
      rd(OFF_PART, PART_ID_DEFAULT, "part id");
      wr(OFF_REV, 8'h00);
      rd(OFF_REV, REV_ID_DEFAULT, "revision id");
      wr(6'h10, 8'hFF);
      rd(6'h10, 8'h00, "reserved");
   endtask : s_ctrl
   task automatic s_alarms;
      wr(OFF_IRQ_EN, 8'hFF);
      rd(OFF_IRQ_EN, 8'h3F, "enable readback");
      wr(OFF_GIRQ_EN, 8'hFF);
      rd(OFF_GIRQ_EN, 8'h01, "global enable readback");
      for (int i = 0; i < 3; i++) begin
         lvl[i] = 1'b1;
         cyc(3);
         irq("alarm irq", 1'b0);
         rd(OFF_IRQ_STAT, lcr_byte_t'(1 << i), "flag rise");
         irq("irq cleared", 1'b1);
         lvl[i] = 1'b0;
         cyc(3);
         rd(OFF_IRQ_STAT, lcr_byte_t'(1 << i), "flag fall");
      end
      lvl[3] = 1'b1;
      cyc(3);
      irq("fifo masked", 1'b1);
      lvl[3] = 1'b0;
      rd(OFF_IRQ_STAT, 8'h00, "fifo off");
      ja = 1'b1;
      cyc(3);
      lvl[3] = 1'b1;
      cyc(3);
      irq("fifo irq", 1'b0);
      rd(OFF_IRQ_STAT, 8'h08, "fifo flag");
      flush_cnt = 0;
      rd(OFF_ALARM, 8'h08, "alarm view");
      chk("flush count", 8'h01, lcr_byte_t'(flush_cnt));
      lvl[3] = 1'b0;
      cyc(3);
      ja = 1'b0;
      rd(OFF_IRQ_STAT, 8'h08, "fifo fall");
   endtask : s_alarms
   task automatic s_pattern;
      wr(OFF_IRQ_EN, 8'h00);
      perr = 1'b1;
      cyc(3);
      perr = 1'b0;
      irq("pattern masked", 1'b1);
      rd(OFF_GIRQ_STAT, 8'h00, "gstat masked");
      rd(OFF_IRQ_STAT, 8'h10, "pattern flag");
      rd(OFF_CNT_LO, 8'h03, "count low");
      rd(OFF_CNT_HI, 8'h00, "count high");
      rd(OFF_HOLD, 8'h03, "holding");
      rd(OFF_CNT_LO, 8'h00, "count cleared");
      wr(OFF_IRQ_EN, 8'h20);
      wr(OFF_GIRQ_EN, 8'h00);
      perr = 1'b1;
      cyc(65536);
      perr = 1'b0;
      irq("global off", 1'b1);
      rd(OFF_GIRQ_STAT, 8'h01, "gstat");
      rd(OFF_CNT_HI, 8'hFF, "saturated high");
      rd(OFF_HOLD, 8'hFF, "saturated low");
      wr(OFF_GIRQ_EN, 8'h01);
      irq("saturation irq", 1'b0);
      rd(OFF_IRQ_STAT, 8'h30, "sat flag");
      irq("all cleared", 1'b1);
   endtask : s_pattern
   initial begin
      repeat (90000) @(posedge mclk);
      bad_count++;
      finish_test();
   end
   initial begin
      cyc(2);
      rst_b = 1'b1;
      cyc(1);
      s_reset();
      s_ctrl();
      s_alarms();
      s_pattern();
      finish_test();
   end
endmodule : tb_liu_control_interrupt_regs
